// ---- rtcd_divider.v ----
// Clock source selection, prescaler, seconds divider with fractional trim,
// output pin routing, write lock and alarm repeat counter.
// Assumes an APB master on pclk; the secondary, internal and line clocks
// arrive as pins and are synchronised here; all sources act as edge enables.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "rtcd_map.vh"

// How it works
// R1 - Bit 11 of the first control register locks the timekeeping registers.
// R2 - Bit 7 enables driving the selected signal onto the clock output pin.
// R3 - The output select field picks alarm, seconds or divided input clock.
// R4 - An alarm event drops the repeat counter by one, except at 00 (see R5) or when an unlocked write loads it that cycle.
// R5 - The counter never wraps from 00 to FF unless rollover is permitted.
// R6 - Bits 31 to 16 of the second register set the divider period.
// R7 - Bits 15 to 11 add that many prescaled ticks over every 16 seconds.
// R8 - Bits 5 to 4 pick a prescale of 1, 16, 64 or 256.
// R9 - Bits 1 to 0 pick the secondary, internal, line or peripheral clock.
// R10 - Bits 10 to 6 and 3 to 2 of the second register read zero.
// R11 - All writable fields of the second register reset to zero.
// R12 - The tick comes from source, then prescaler, then divider.
// R13 - While locked, writes to locked registers leave them unchanged.
module rtcd_divider
(
   input  wire        pclk,                 // Bus and logic clock.
   input  wire        presetn,              // Asynchronous reset, low.
   input  wire        psel,                 // APB select.
   input  wire        penable,              // APB enable.
   input  wire        pwrite,               // APB write direction.
   input  wire [11:0] paddr,                // APB byte address.
   input  wire [31:0] pwdata,               // APB write data.
   output reg  [31:0] prdata,               // APB read data.
   output reg         pready,               // APB ready.
   output reg         pslverr,              // APB error, unmapped address.
   input  wire        secondary_oscillator, // Secondary oscillator pin.
   input  wire        low_power_internal_osc, // Internal RC clock.
   input  wire        power_line_clock_pin, // Power line clock pin.
   input  wire        alarm_event,          // One-cycle alarm pulse.
   output reg         calendar_clock,       // Clock output pin level.
   output reg         calendar_clock_oe_n,  // Output enable, low drives.
   output reg         seconds_tick          // One-cycle seconds pulse.
);

   ////////////////////////////////////////////////////////////////////////
   // Register state.
   reg         timekeeping_write_lock;
   reg         clock_out_enable;
   reg  [2:0]  output_signal_select;
   reg  [15:0] divider_period;
   reg  [4:0]  fractional_trim;
   reg  [1:0]  prescale_select;
   reg  [1:0]  timekeeping_source_select;
   reg  [7:0]  repeat_count;
   reg         rollover_permit;

   // Synchronisers: first stage is read only by the second.
   reg  [2:0]  sync_a;
   reg  [2:0]  sync_b;
   reg         src_prev;

   // Tick chain state.
   reg  [7:0]  pre_count;
   reg  [15:0] div_count;
   reg  [4:0]  trim_count;
   reg  [3:0]  sec_index;
   reg         in_trim;
   reg         div_clk;
   reg         alarm_seen;

   wire        access;
   wire        wr_en;
   wire        src_level;
   wire        src_edge;
   wire [7:0]  pre_tc;
   wire        pre_tick;
   wire        div_done;
   wire [4:0]  trim_due;
   reg  [31:0] next_prdata;
   reg         next_pin;

   // Terminal count of the prescaler for a prescale code.
   function [7:0] pre_limit;
      input [1:0] code;
      begin
         case (code)
            `RTCD_PS_16:  pre_limit = `RTCD_PSTC_16;
            `RTCD_PS_64:  pre_limit = `RTCD_PSTC_64;
            `RTCD_PS_256: pre_limit = `RTCD_PSTC_256;
            default:      pre_limit = `RTCD_PSTC_1;
         endcase
      end
   endfunction

   // True when an address matches a register offset.
   function hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, ready in the access phase.
   assign access = psel & penable;
   assign wr_en  = access & pwrite;

   // Read mux; unimplemented bits and unmapped offsets read zero.
   always @*
   begin
      next_prdata = `RTCD_RST_WORD;
      if (hit(paddr, `RTCD_OFS_CTRL1))
      begin
         next_prdata[`RTCD_LOCK_BIT] = timekeeping_write_lock;
         next_prdata[`RTCD_OE_BIT]   = clock_out_enable;
         next_prdata[`RTCD_OSEL_HI:`RTCD_OSEL_LO] = output_signal_select;
      end
      else if (hit(paddr, `RTCD_OFS_DIVCTRL))
      begin
         next_prdata[`RTCD_DIV_HI:`RTCD_DIV_LO]   = divider_period;
         next_prdata[`RTCD_FDIV_HI:`RTCD_FDIV_LO] = fractional_trim; // [R10]
         next_prdata[`RTCD_PS_HI:`RTCD_PS_LO]     = prescale_select;
         next_prdata[`RTCD_CSEL_HI:`RTCD_CSEL_LO] =
            timekeeping_source_select;
      end
      else if (hit(paddr, `RTCD_OFS_ALARMCNT))
      begin
         next_prdata[`RTCD_RPT_HI:`RTCD_RPT_LO] = repeat_count;
         next_prdata[`RTCD_ROLL_BIT]           = rollover_permit;
      end
      else if (hit(paddr, `RTCD_OFS_STATUS))
      begin
         next_prdata[`RTCD_STAT_PIN_BIT]  = calendar_clock;
         next_prdata[`RTCD_STAT_DCLK_BIT] = div_clk;
      end
   end

   // Bus answer registers; ready is raised in the setup cycle so the
   // access phase completes on its first edge.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= `RTCD_RST_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         prdata  <= next_prdata;
         pslverr <= psel & ~penable &
                    ~(hit(paddr, `RTCD_OFS_CTRL1) |
                      hit(paddr, `RTCD_OFS_DIVCTRL) |
                      hit(paddr, `RTCD_OFS_ALARMCNT) |
                      hit(paddr, `RTCD_OFS_STATUS));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // First control register. The lock bit itself stays writable so
   // software can release it.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timekeeping_write_lock <= 1'b0;
         clock_out_enable       <= 1'b0;
         output_signal_select   <= `RTCD_OSEL_ALARM;
      end
      else if (wr_en && hit(paddr, `RTCD_OFS_CTRL1))
      begin
         timekeeping_write_lock <= pwdata[`RTCD_LOCK_BIT]; // [R1]
         clock_out_enable       <= pwdata[`RTCD_OE_BIT];
         output_signal_select   <= pwdata[`RTCD_OSEL_HI:`RTCD_OSEL_LO];
      end
   end

   // Divider control: ignored while locked, reserved bits dropped.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         divider_period            <= 16'h0000;            // [R11]
         fractional_trim           <= 5'h00;
         prescale_select           <= `RTCD_PS_1;
         timekeeping_source_select <= `RTCD_CSEL_SECONDARY_OSCILLATOR;
      end
      else if (wr_en && hit(paddr, `RTCD_OFS_DIVCTRL) &&
               !timekeeping_write_lock)                    // [R1] [R13]
      begin
         divider_period  <= pwdata[`RTCD_DIV_HI:`RTCD_DIV_LO];    // [R6]
         fractional_trim <= pwdata[`RTCD_FDIV_HI:`RTCD_FDIV_LO];  // [R7]
         prescale_select <= pwdata[`RTCD_PS_HI:`RTCD_PS_LO];      // [R8]
         timekeeping_source_select <=
            pwdata[`RTCD_CSEL_HI:`RTCD_CSEL_LO];                  // [R9]
      end
   end

   // Alarm repeat counter. An unlocked software write wins over a same-cycle alarm
   // decrement because it carries the fresh intended value.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         repeat_count    <= `RTCD_RST_RPT;
         rollover_permit <= 1'b0;
      end
      else if (wr_en && hit(paddr, `RTCD_OFS_ALARMCNT) &&
               !timekeeping_write_lock)                    // [R13]
      begin
         repeat_count    <= pwdata[`RTCD_RPT_HI:`RTCD_RPT_LO];
         rollover_permit <= pwdata[`RTCD_ROLL_BIT];
      end
      else if (alarm_event)                                // [R4]
      begin
         if (repeat_count != `RTCD_RST_RPT)
            repeat_count <= repeat_count - `RTCD_ONE8;
         else if (rollover_permit)                         // [R5]
            repeat_count <= `RTCD_RPT_MAX;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source clocks are pins: two flops each, then pick one and find its
   // rising edge. The peripheral clock is pclk itself, so every cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_a   <= 3'h0;
         sync_b   <= 3'h0;
         src_prev <= 1'b0;
      end
      else
      begin
         sync_a   <= {power_line_clock_pin, low_power_internal_osc,
                      secondary_oscillator};
         sync_b   <= sync_a;
         src_prev <= src_level;
      end
   end

   assign src_level = (timekeeping_source_select == `RTCD_CSEL_LOW_POWER_INTERNAL_OSC) ?
                      sync_b[1] :
                      (timekeeping_source_select == `RTCD_CSEL_PWRL) ?
                      sync_b[2] : sync_b[0];
   assign src_edge  = (timekeeping_source_select == `RTCD_CSEL_PCLK) ?
                      1'b1 : (src_level & ~src_prev);       // [R9]

   ////////////////////////////////////////////////////////////////////////
   // Prescaler then divider; the trim adds prescaled ticks over a 16 s
   // window. Terminal tests use greater-or-equal so that a setting made
   // smaller mid-count ends the period at once instead of waiting for
   // the counter to wrap.
   assign pre_tc   = pre_limit(prescale_select);            // [R8]
   assign pre_tick = src_edge && (pre_count >= pre_tc);
   assign div_done = (div_count >= divider_period);

   // A trim of n gives n div 16 extra ticks in every second and one more
   // in each of the first n mod 16 seconds, so n in total per window.
   assign trim_due = {4'h0, fractional_trim[4]} +
                     ((sec_index < fractional_trim[3:0]) ? 5'h01 : 5'h00);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_count    <= `RTCD_PSTC_1;
         div_count    <= 16'h0000;
         trim_count   <= 5'h00;
         sec_index    <= 4'h0;
         in_trim      <= 1'b0;
         div_clk      <= 1'b0;
         seconds_tick <= 1'b0;
      end
      else
      begin
         seconds_tick <= 1'b0;
         if (src_edge)
            pre_count <= pre_tick ? `RTCD_PSTC_1 : pre_count + `RTCD_ONE8;
         if (pre_tick)                                      // [R12]
         begin
            if (in_trim)
            begin
               // Extra ticks for the fractional trim, one per prescaled
               // tick; the second ends with the last of them.
               if (trim_count == 5'h01)
               begin
                  in_trim      <= 1'b0;                     // [R7]
                  seconds_tick <= 1'b1;
                  sec_index    <= sec_index + 4'h1;
               end
               trim_count <= trim_count - 5'h01;
            end
            else if (div_done)                              // [R6]
            begin
               div_count <= 16'h0000;
               div_clk   <= ~div_clk;                       // [R3]
               if (trim_due != 5'h00)
               begin
                  in_trim    <= 1'b1;                       // [R7]
                  trim_count <= trim_due;
               end
               else
               begin
                  seconds_tick <= 1'b1;
                  sec_index <= sec_index + 4'h1;
               end
            end
            else
               div_count <= div_count + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarm is stretched into a level that toggles per event for the pin.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         alarm_seen <= 1'b0;
      else if (alarm_event)
         alarm_seen <= ~alarm_seen;
   end

   // Output pin routing; reserved codes drive low.
   always @*
   begin
      case (output_signal_select)                           // [R3]
         `RTCD_OSEL_ALARM:   next_pin = alarm_seen;
         `RTCD_OSEL_SECONDS: next_pin = seconds_tick;
         `RTCD_OSEL_DIVCLK:  next_pin = div_clk;
         default:            next_pin = 1'b0;
      endcase
   end

   // Pin drive; disabled output floats with enable high.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         calendar_clock      <= 1'b0;
         calendar_clock_oe_n <= 1'b1;
      end
      else
      begin
         calendar_clock      <= clock_out_enable & next_pin;    // [R2]
         calendar_clock_oe_n <= ~clock_out_enable;              // [R2]
      end
   end

endmodule // rtcd_divider

// ---- rtcd_map.vh ----
// Register offsets, field positions and reset values for the
// timekeeping clock divider and output control block.
// Assumes a 32-bit APB bus with word-aligned registers.
`ifndef RTCD_MAP_VH
`define RTCD_MAP_VH

// Register byte offsets.
`define RTCD_OFS_CTRL1      12'h000
`define RTCD_OFS_DIVCTRL    12'h004
`define RTCD_OFS_ALARMCNT   12'h008
`define RTCD_OFS_STATUS     12'h00C

// First control register fields.
`define RTCD_LOCK_BIT       11
`define RTCD_OE_BIT         7
`define RTCD_OSEL_HI        6
`define RTCD_OSEL_LO        4

// Second control register fields.
`define RTCD_DIV_HI         31
`define RTCD_DIV_LO         16
`define RTCD_FDIV_HI        15
`define RTCD_FDIV_LO        11
`define RTCD_PS_HI          5
`define RTCD_PS_LO          4
`define RTCD_CSEL_HI        1
`define RTCD_CSEL_LO        0

// Alarm repeat register fields.
`define RTCD_RPT_HI         7
`define RTCD_RPT_LO         0
`define RTCD_ROLL_BIT       8

// Status register fields.
`define RTCD_STAT_PIN_BIT   7
`define RTCD_STAT_DCLK_BIT  0

// Output select codes.
`define RTCD_OSEL_ALARM     3'h0
`define RTCD_OSEL_SECONDS   3'h1
`define RTCD_OSEL_DIVCLK    3'h2

// Clock source codes.
`define RTCD_CSEL_SECONDARY_OSCILLATOR      2'h0
`define RTCD_CSEL_LOW_POWER_INTERNAL_OSC      2'h1
`define RTCD_CSEL_PWRL      2'h2
`define RTCD_CSEL_PCLK      2'h3

// Prescale codes and terminal counts (ratio minus one).
`define RTCD_PS_1           2'h0
`define RTCD_PS_16          2'h1
`define RTCD_PS_64          2'h2
`define RTCD_PS_256         2'h3
`define RTCD_PSTC_1         8'h00
`define RTCD_PSTC_16        8'h0F
`define RTCD_PSTC_64        8'h3F
`define RTCD_PSTC_256       8'hFF

// Seconds per fractional trim window, minus one.
`define RTCD_FWIN_LAST      4'hF

// Reset values and counter constants.
`define RTCD_RST_WORD       32'h0000_0000
`define RTCD_RST_RPT        8'h00
`define RTCD_RPT_MAX        8'hFF
`define RTCD_ONE8           8'h01

`endif

// ---- rtcd_divider_properties.sv ----
// Port checks for the timekeeping divider block.
// Bound from the bench; shadows the bus writes it needs.
`timescale 1ns/1ps
module rtcd_divider_properties
(
   input wire        pclk,               // Clock.
   input wire        presetn,            // Reset, low.
   input wire        psel,               // Select.
   input wire        penable,            // Enable.
   input wire        pwrite,             // Direction.
   input wire [11:0] paddr,              // Address.
   input wire [31:0] pwdata,             // Write data.
   input wire [31:0] prdata,             // Read data.
   input wire        pready,             // Ready.
   input wire        pslverr,            // Error.
   input wire        alarm_event,        // Alarm pulse.
   input wire        calendar_clock,     // Pin level.
   input wire        calendar_clock_oe_n // Pin enable, low.
);
////////////////////////////////////////////////////////////////////////
reg  [4:0]  ctl_q; // Lock, enable and select last written.
reg  [31:0] div_q; // Expected divider register.
reg  [2:0]  age_q; // Cycles since a first-register write, capped at 4.
wire        acc = psel && penable && pready;
wire        wr1 = acc && pwrite && paddr == 12'h000;

// The lock gates the shadow just as it must gate the real register.
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ctl_q <= 5'h00;
      div_q <= 32'h0000_0000;
      age_q <= 3'h0;
   end
   else
   begin
      if (wr1)
         ctl_q <= {pwdata[11], pwdata[7:4]};
      if (acc && pwrite && paddr == 12'h004 && !ctl_q[4])
         div_q <= pwdata & 32'hFFFF_F833;
      if (wr1)
         age_q <= 3'h0;
      else if (age_q != 3'h4)
         age_q <= age_q + 3'h1;
   end
end

////////////////////////////////////////////////////////////////////////
// The outputs are given four cycles to settle after a control write.
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
sequence setup_s;
   psel && !penable;
endsequence
sequence access_s;
   psel && penable;
endsequence

pready_access_a: assert property (setup_s ##1 access_s |-> pready)
   else $error("ready missing in access cycle");
pready_idle_a: assert property (!(psel && penable) |-> !pready)
   else $error("ready outside access cycle");
slverr_unmapped_a: assert property (acc && paddr > 12'h00C |->
   pslverr && (pwrite || prdata == 32'h0000_0000))
   else $error("unmapped access not flagged");
no_error_mapped_a: assert property (acc && paddr <= 12'h00C |-> !pslverr)
   else $error("error on mapped access");
sequence settled_s;
   age_q == 3'h4;
endsequence
sequence alarm_s;
   ctl_q[3] && ctl_q[2:0] == 3'h0 && alarm_event;
endsequence
property div_read_p;
   acc && !pwrite && paddr == 12'h004 |-> prdata == div_q;
endproperty
property oe_follow_p;
   settled_s |-> calendar_clock_oe_n == !ctl_q[3];
endproperty
property reserved_out_p;
   settled_s ##0 ctl_q[2:0] > 3'h2 |-> !calendar_clock;
endproperty
property alarm_pin_p;
   settled_s ##0 alarm_s |-> ##[1:3] $changed(calendar_clock);
endproperty

divider_readback_a: assert property (div_read_p)
   else $error("divider register read wrong");
oe_follow_a: assert property (oe_follow_p)
   else $error("pin enable wrong");
reserved_out_a: assert property (reserved_out_p)
   else $error("reserved select drives pin");
alarm_pin_a: assert property (alarm_pin_p)
   else $error("alarm not seen on pin");
endmodule // rtcd_divider_properties

// ---- rtcd_divider_bench.sv ----
// Self-checking bench for the timekeeping divider block.
// Drives the bus, the source pins and the alarm pulse itself.
`timescale 1ns/1ps
module rtcd_divider_bench;
typedef struct packed {
   logic        w;
   logic [11:0] a;
   logic [31:0] d;
   logic [31:0] x;
   logic        er;
} rtcd_row_t;
////////////////////////////////////////////////////////////////////////
logic        pclk = 1'b0;
logic        presetn = 1'b0;
logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0000_0000, prdata, r;
logic        pready, pslverr, e, alarm_event = 1'b0;
logic        calendar_clock, calendar_clock_oe_n, seconds_tick;
logic        secondary_oscillator = 1'b0, low_power_internal_osc = 1'b0;
logic        power_line_clock_pin = 1'b0;
integer      err_total = 0, check_count = 0, cyc = 0, i, n, s;
int          rate [4] = '{6, 8, 10, 1};
rtcd_row_t   rows [12] = '{
   '{1'b0, 12'h000, 32'h0, 32'h0000_0000, 1'b0},
   '{1'b0, 12'h004, 32'h0, 32'h0000_0000, 1'b0},
   '{1'b0, 12'h008, 32'h0, 32'h0000_0000, 1'b0},
   '{1'b1, 12'h004, 32'hFFFF_FFFF, 32'h0, 1'b0},
   '{1'b0, 12'h004, 32'h0, 32'hFFFF_F833, 1'b0},
   '{1'b1, 12'h000, 32'hFFFF_FFFF, 32'h0, 1'b0},
   '{1'b0, 12'h000, 32'h0, 32'h0000_08F0, 1'b0},
   '{1'b1, 12'h004, 32'h0000_0000, 32'h0, 1'b0},
   '{1'b0, 12'h004, 32'h0, 32'hFFFF_F833, 1'b0},
   '{1'b0, 12'h010, 32'h0, 32'h0000_0000, 1'b1},
   '{1'b1, 12'h000, 32'h0000_0000, 32'h0, 1'b0},
   '{1'b1, 12'h004, 32'h0000_0000, 32'h0, 1'b0}};

rtcd_divider i_rtcd_divider
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .secondary_oscillator(secondary_oscillator),
   .low_power_internal_osc(low_power_internal_osc),
   .power_line_clock_pin(power_line_clock_pin),
   .alarm_event(alarm_event), .calendar_clock(calendar_clock),
   .calendar_clock_oe_n(calendar_clock_oe_n), .seconds_tick(seconds_tick)
);

////////////////////////////////////////////////////////////////////////
// Clock at 40 MHz.
always #12.5 pclk = ~pclk;

// Source pins with rising edges every 6, 8 and 10 cycles.
always @(posedge pclk)
begin
   cyc <= cyc + 1;
   secondary_oscillator <= (cyc % 6) < 3;
   low_power_internal_osc <= (cyc % 8) < 4;
   power_line_clock_pin <= (cyc % 10) < 5;
end

task summarize;
   begin
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
endtask

task check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, seen, exp);
      end
   end
endtask

// One transfer; an edge passes after release so strobes never double up.
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   integer k;
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         err_total++;
         summarize;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   end
endtask

// Cycles from one seconds pulse to the next; a hang ends the run.
task gap;
   begin
      n = 0;
      while (seconds_tick !== 1'b1 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (seconds_tick !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
         err_total++;
         summarize;
      end
   end
endtask

// Cycles between two changes of the pin level; a hang ends the run.
task flip;
   logic v;
   begin
      n = 0;
      v = calendar_clock;
      while (calendar_clock === v && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      v = calendar_clock;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (calendar_clock === v && n < 300);
      if (n >= 300)
      begin
         err_total++;
         summarize;
      end
   end
endtask

task pulse;
   begin
      alarm_event <= 1'b1;
      @(posedge pclk);
      alarm_event <= 1'b0;
      repeat (4) @(posedge pclk);
   end
endtask

////////////////////////////////////////////////////////////////////////
// Register rows first, then timing, alarm counter and reset cases.
initial
begin
   repeat (5) @(posedge pclk);
   presetn <= 1'b1;
   @(posedge pclk);
   for (i = 0; i < 12; i++)
   begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
         check(r, rows[i].x);
      check({31'h0, e}, {31'h0, rows[i].er});
   end
   for (i = 0; i < 4; i++)
   begin
      apb(1'b1, 12'h004, {16'h0002, 14'h0000, i[1:0]});
      gap;
      gap;
      check(n, 3 * rate[i]);
   end
   for (i = 0; i < 4; i++)
   begin
      apb(1'b1, 12'h004, {16'h0001, 10'h000, i[1:0], 4'h3});
      gap;
      gap;
      check(n, 2 << (i == 0 ? 0 : 2 * i + 2));
   end
   // Trims of 5 and 17 over 16 seconds of 4 cycles each.
   for (i = 0; i < 2; i++)
   begin
      apb(1'b1, 12'h004, {16'h0003, i ? 5'h11 : 5'h05, 9'h000, 2'h3});
      gap;
      s = 0;
      repeat (16)
      begin
         gap;
         s += n;
      end
      check(s, i ? 81 : 69);
   end
   // Seconds pulse, then divided clock, routed to the pin.
   apb(1'b1, 12'h004, 32'h0003_0003);
   apb(1'b1, 12'h000, 32'h0000_0090);
   gap;
   @(posedge pclk);
   check({31'h0, calendar_clock}, 32'h0000_0001);
   @(posedge pclk);
   check({31'h0, calendar_clock}, 32'h0000_0000);
   apb(1'b1, 12'h000, 32'h0000_00A0);
   flip;
   check(n, 4);
   apb(1'b1, 12'h000, 32'h0000_0080);
   apb(1'b1, 12'h008, 32'h0000_0002);
   pulse;
   apb(1'b0, 12'h008, 32'h0);
   check(r, 32'h0000_0001);
   pulse;
   pulse;
   apb(1'b0, 12'h008, 32'h0);
   check(r, 32'h0000_0000);
   apb(1'b1, 12'h008, 32'h0000_0100);
   pulse;
   apb(1'b0, 12'h008, 32'h0);
   check(r, 32'h0000_01FF);
   apb(1'b1, 12'h000, 32'h0000_0880);
   apb(1'b1, 12'h008, 32'h0000_0005);
   pulse;
   apb(1'b0, 12'h008, 32'h0);
   check(r, 32'h0000_01FE);
   apb(1'b1, 12'h000, 32'h0000_00B0);
   repeat (6) @(posedge pclk);
   presetn <= 1'b0;
   repeat (2) @(posedge pclk);
   presetn <= 1'b1;
   @(posedge pclk);
   apb(1'b0, 12'h004, 32'h0);
   check(r, 32'h0000_0000);
   summarize;
end
endmodule // rtcd_divider_bench

bind rtcd_divider rtcd_divider_properties i_rtcd_divider_properties
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .alarm_event(alarm_event),
   .calendar_clock(calendar_clock),
   .calendar_clock_oe_n(calendar_clock_oe_n)
);
